// file: common/mac_simd_pkg.sv
// Constants and types for the custom multiply and packed-lane datapath.
package mac_simd_pkg;

  // Opcodes of the custom instruction groups.
  localparam logic [6:0] opcode_branch_imm = 7'h0b;
  localparam logic [6:0] opcode_alu_mac    = 7'h2b;
  localparam logic [6:0] opcode_half_mul   = 7'h5b;

  // Function codes of the immediate branches.
  localparam logic [2:0] f3_branch_eq = 3'h6;
  localparam logic [2:0] f3_branch_ne = 3'h7;

  // Function codes of the full-width multiply-accumulate group.
  localparam logic [2:0] f3_full_mac   = 3'h3;
  localparam logic [6:0] f7_full_mac   = 7'h48;
  localparam logic [6:0] f7_full_msu   = 7'h49;

  // Function-3 codes of the half-word multiply group.
  localparam logic [2:0] f3_half_mul_s = 3'h4;
  localparam logic [2:0] f3_half_mul_u = 3'h5;
  localparam logic [2:0] f3_half_mac_s = 3'h6;
  localparam logic [2:0] f3_half_mac_u = 3'h7;

  // Instruction field positions.
  localparam int opcode_lsb   = 0;
  localparam int f3_lsb       = 12;
  localparam int cmp_imm_lsb  = 20;
  localparam int f7_lsb       = 25;
  localparam int shamt_lsb    = 25;
  localparam int variant_lsb  = 30;
  localparam int sign_bit     = 31;
  localparam int off_hi_lsb   = 25;
  localparam int off_lo_lsb   = 8;
  localparam int off_b11_bit  = 7;

  // Branch offset is scaled by one bit position.
  localparam int branch_shift = 1;

  // Variant select field encodings.
  localparam logic [1:0] variant_low      = 2'h0;
  localparam logic [1:0] variant_high     = 2'h1;
  localparam logic [1:0] variant_low_rnd  = 2'h2;
  localparam logic [1:0] variant_high_rnd = 2'h3;

  // Lane geometry.
  localparam int byte_w  = 8;
  localparam int half_w  = 16;
  localparam int n_bytes = 4;
  localparam int n_halfs = 2;

  // Packed-lane operation select.
  typedef enum logic [2:0] {
    simd_add = 3'h0,
    simd_sub = 3'h1,
    simd_and = 3'h2,
    simd_or  = 3'h3,
    simd_xor = 3'h4,
    simd_min = 3'h5,
    simd_max = 3'h6
  } simd_op_t;

  // Second operand source for packed-lane operations.
  typedef enum logic [1:0] {
    mode_vector             = 2'h0,
    scalar_replication_mode = 2'h1,
    mode_immediate          = 2'h3
  } simd_mode_t;

endpackage : mac_simd_pkg

// file: hw/custom_mac_simd_datapath.sv
// Execute-stage datapath for immediate branches, multiply and packed lanes.
`timescale 1ns/1ns
`default_nettype none

module custom_mac_simd_datapath
  import mac_simd_pkg::*;
#(
  parameter bit custom_extension_enable_param = 1'b1
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        issue_valid,
  input  wire logic [31:0] instruction,
  input  wire logic [31:0] program_counter,
  input  wire logic [31:0] source_one,
  input  wire logic [31:0] source_two,
  input  wire logic [31:0] destination_old,
  input  wire logic        simd_valid,
  input  wire logic        simd_byte_lanes,
  input  wire logic [2:0]  simd_operation,
  input  wire logic [1:0]  simd_operand_mode,
  input  wire logic        simd_unsigned,
  input  wire logic [5:0]  simd_immediate,
  output logic             result_valid,
  output logic [31:0]      result,
  output logic             branch_taken,
  output logic [31:0]      branch_target,
  output logic             illegal_instruction
);

  // All state of the block, registered once per clock.
  // Every output is a flop so that the decode stage sees clean values.
  // Answers last exactly one cycle because the next state is rebuilt
  // from zero on every edge; nothing is remembered between issues.
  typedef struct packed {
    logic        result_valid;
    logic [31:0] result;
    logic        branch_taken;
    logic [31:0] branch_target;
    logic        illegal_instruction;
  } state_t;

  state_t state;
  state_t next_state;

  // Field map of the custom words, from the top bit down:
  // variant select in 31:30 and post shift in 29:25 for half multiplies,
  // function code seven in 31:25 for the full-width group,
  // second register or compare immediate in 24:20,
  // first register in 19:15, function code three in 14:12,
  // destination in 11:7 and opcode in 6:0.
  // Decoded fields.
  // The register fields are not decoded here: the register file has
  // already turned them into operand values on the source ports.
  // Fields are sliced unconditionally; the class flags decide which count.
  logic [6:0]  opcode;
  logic [2:0]  function_code_three;
  logic [6:0]  function_code_seven;
  logic [1:0]  variant_select_field;
  logic [4:0]  post_shift_amount;
  logic [4:0]  compare_immediate;
  logic [12:0] branch_offset;

  assign opcode               = instruction[opcode_lsb +: 7];
  assign function_code_three  = instruction[f3_lsb +: 3];
  assign function_code_seven  = instruction[f7_lsb +: 7];
  assign variant_select_field = instruction[variant_lsb +: 2];
  assign post_shift_amount    = instruction[shamt_lsb +: 5];
  assign compare_immediate    = instruction[cmp_imm_lsb +: 5];

  // Offset bits are scattered as in a standard conditional branch.
  // Bit 0 is always zero, which gives the left shift by one for free.
  assign branch_offset = {instruction[sign_bit],
                          instruction[off_b11_bit],
                          instruction[off_hi_lsb +: 6],
                          instruction[off_lo_lsb +: 4],
                          1'b0};

  // Instruction class recognition.
  // Only the fields that tell the classes apart are compared; the
  // accumulate group shares its opcode with other scalar extensions,
  // so both function codes must match before it counts as ours.
  logic is_branch;
  logic is_full_mac;
  logic is_half_mul;

  assign is_branch = (opcode == opcode_branch_imm) &&
                     (function_code_three == f3_branch_eq ||
                      function_code_three == f3_branch_ne);
  assign is_full_mac = (opcode == opcode_alu_mac) &&
                       (function_code_three == f3_full_mac) &&
                       (function_code_seven == f7_full_mac ||
                        function_code_seven == f7_full_msu);
  assign is_half_mul = (opcode == opcode_half_mul) &&
                       function_code_three[2];

  // Branch compare and target; the assembled offset carries bit 0 already.
  // The compare immediate is signed, so minus one matches all ones.
  // The adder wraps silently at the top of the address space.
  // The target is reported whether or not the branch is taken.
  logic [31:0] compare_value;
  logic        sources_equal;
  logic [31:0] target;

  assign compare_value = {{27{compare_immediate[4]}}, compare_immediate};
  assign sources_equal = (source_one == compare_value);
  assign target = program_counter +
                  {{19{branch_offset[12]}}, branch_offset};

  // Full-width product, low 32 bits only.
  // Signedness does not matter for the low half of a product, so one
  // unsigned multiplier serves both the accumulate and the subtract.
  // Accumulate and subtract both wrap modulo two to the 32, with no flag.
  logic [31:0] full_product;
  logic [31:0] full_mac_value;

  assign full_product = 32'(source_one * source_two);
  assign full_mac_value = (function_code_seven == f7_full_mac) ?
                          destination_old + full_product :
                          destination_old - full_product;

  // Half-word multiply operand selection and extension.
  // Operands are extended to the full sum width so that the product of
  // two negative or mixed-sign halves keeps its sign in the top bit.
  logic        half_signed;
  logic        half_high;
  logic        half_round;
  logic        half_accumulate;
  logic [15:0] half_a;
  logic [15:0] half_b;
  logic [33:0] ext_a;
  logic [33:0] ext_b;
  logic [33:0] half_sum;
  logic [33:0] round_const;
  logic [33:0] shifted;

  // The low function-code bit chooses unsigned, the middle one chooses
  // accumulate; bit 30 picks the high halves and bit 31 asks for rounding.
  assign half_signed = ~function_code_three[0];
  assign half_accumulate = function_code_three[1];
  assign half_high = variant_select_field[0];
  assign half_round = variant_select_field[1];

  // The high variants take the upper halves of both sources together.
  assign half_a = half_high ? source_one[31:16] : source_one[15:0];
  assign half_b = half_high ? source_two[31:16] : source_two[15:0];
  assign ext_a = half_signed ? {{18{half_a[15]}}, half_a} :
                               {18'h0, half_a};
  assign ext_b = half_signed ? {{18{half_b[15]}}, half_b} :
                               {18'h0, half_b};

  // A zero shift would ask for half a bit; it rounds by nothing instead.
  // Rounding adds half of the weight of the lowest kept bit, so the
  // result is rounded to nearest with ties going upwards.
  // The shift amount minus one cannot underflow: zero is caught first.
  assign round_const = (half_round && post_shift_amount != 5'h0) ?
                       34'(34'h1 << (post_shift_amount - 5'h1)) :
                       34'h0;

  // Extra headroom bits keep the pre-shift sum exact for both signs.
  // A signed sum fits in 33 bits and the 34th holds its sign; an unsigned sum stays within 33 unless accumulate and rounding together push it into the 34th.
  // Only the low 32 bits of the shifted sum reach the result, so a large
  // unsigned sum with a small shift drops its top bits, as in software.
  logic [33:0] acc_ext;

  assign acc_ext = half_accumulate ?
                   (half_signed ? {{2{destination_old[31]}}, destination_old}
                                : {2'h0, destination_old}) :
                   34'h0;
  assign half_sum = ext_a * ext_b + acc_ext + round_const;
  // The shift is logical for unsigned words and arithmetic for signed.
  assign shifted = half_signed ?
                   34'($signed(half_sum) >>> post_shift_amount) :
                   34'(half_sum >> post_shift_amount);

  // Packed-lane second operand.
  // The immediate is six bits wide and is widened to the lane width;
  // the unsigned flag selects zero extension for the operations that
  // want it, and sign extension is the default.
  logic [31:0] simd_op2;
  logic [15:0] imm_half;
  logic [7:0]  imm_byte;

  assign imm_half = simd_unsigned ? {10'h0, simd_immediate} :
                    {{10{simd_immediate[5]}}, simd_immediate};
  assign imm_byte = simd_unsigned ? {2'h0, simd_immediate} :
                    {{2{simd_immediate[5]}}, simd_immediate};

  // Lane zero always comes from the lowest bits of the source.
  // The unused mode code falls back to the vector operand rather than
  // producing an unknown value.
  always_comb begin
    unique case (simd_operand_mode)
      mode_vector: begin
        simd_op2 = source_two;
      end
      scalar_replication_mode: begin
        simd_op2 = simd_byte_lanes ? {n_bytes{source_two[7:0]}} :
                   {n_halfs{source_two[15:0]}};
      end
      mode_immediate: begin
        simd_op2 = simd_byte_lanes ? {n_bytes{imm_byte}} :
                   {n_halfs{imm_half}};
      end
      default: begin
        simd_op2 = source_two;
      end
    endcase
  end

  // Byte lanes, each wrapping on its own width.
  // Each lane has its own narrow adder, so a carry can never leave it;
  // this costs a few gates over one wide adder with blocked carries.
  logic [31:0] byte_result;
  logic [31:0] half_result;

  // One loop per lane width; the lane index is the loop variable.
  genvar lane;
  generate
    for (lane = 0; lane < n_bytes; lane++) begin : g_byte
      logic [7:0] a;
      logic [7:0] b;
      logic       less;
      assign a = source_one[lane*byte_w +: byte_w];
      assign b = simd_op2[lane*byte_w +: byte_w];
      assign less = simd_unsigned ? (a < b) : ($signed(a) < $signed(b));
      always_comb begin
        unique case (simd_op_t'(simd_operation))
          simd_add: byte_result[lane*byte_w +: byte_w] = a + b;
          simd_sub: byte_result[lane*byte_w +: byte_w] = a - b;
          simd_and: byte_result[lane*byte_w +: byte_w] = a & b;
          simd_or:  byte_result[lane*byte_w +: byte_w] = a | b;
          simd_xor: byte_result[lane*byte_w +: byte_w] = a ^ b;
          simd_min: byte_result[lane*byte_w +: byte_w] = less ? a : b;
          simd_max: byte_result[lane*byte_w +: byte_w] = less ? b : a;
          default:  byte_result[lane*byte_w +: byte_w] = a + b;
        endcase
      end
    end
    // Half-word lanes, built the same way on wider slices.
    // Both lane sets are always computed; the lane flag only picks one.
    for (lane = 0; lane < n_halfs; lane++) begin : g_half
      logic [15:0] a;
      logic [15:0] b;
      logic        less;
      assign a = source_one[lane*half_w +: half_w];
      assign b = simd_op2[lane*half_w +: half_w];
      assign less = simd_unsigned ? (a < b) : ($signed(a) < $signed(b));
      always_comb begin
        unique case (simd_op_t'(simd_operation))
          simd_add: half_result[lane*half_w +: half_w] = a + b;
          simd_sub: half_result[lane*half_w +: half_w] = a - b;
          simd_and: half_result[lane*half_w +: half_w] = a & b;
          simd_or:  half_result[lane*half_w +: half_w] = a | b;
          simd_xor: half_result[lane*half_w +: half_w] = a ^ b;
          simd_min: half_result[lane*half_w +: half_w] = less ? a : b;
          simd_max: half_result[lane*half_w +: half_w] = less ? b : a;
          default:  half_result[lane*half_w +: half_w] = a + b;
        endcase
      end
    end
  endgenerate

  // Choose the outcome of the issued operation; packed ops outrank decode.
  // Packed operations come with their own valid, so a scalar word that
  // happens to arrive together with one is ignored for that cycle.
  // With the extension off, only the immediate branches stay legal.
  // Unknown words are flagged as illegal and produce no result, and a
  // flagged word leaves the result at zero so nothing stale is written.
  always_comb begin
    next_state = '0;
    if (simd_valid) begin
      next_state.result_valid = custom_extension_enable_param;
      next_state.illegal_instruction = !custom_extension_enable_param;
      next_state.result = custom_extension_enable_param ?
        (simd_byte_lanes ? byte_result : half_result) : 32'h0;
    end else if (issue_valid) begin
      if (is_branch) begin
        next_state.branch_taken =
          (function_code_three == f3_branch_eq) ? sources_equal
                                                : !sources_equal;
        next_state.branch_target = target;
        next_state.result_valid = 1'b1;
      end else if ((is_full_mac || is_half_mul) &&
                   !custom_extension_enable_param) begin
        next_state.illegal_instruction = 1'b1;
      end else if (is_full_mac) begin
        next_state.result_valid = 1'b1;
        next_state.result = full_mac_value;
      end else if (is_half_mul) begin
        next_state.result_valid = 1'b1;
        next_state.result = shifted[31:0];
      end else begin
        next_state.illegal_instruction = 1'b1;
      end
    end
  end

  // Single register stage for every output.
  // The reset clears the whole state at once, so no answer survives it.
  // It acts without a clock, so the outputs go quiet at once.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs are straight copies of the registered state.
  // Keeping them in one struct makes it plain that they all change on
  // the same edge and that none of them is decoded after the flops.
  assign result_valid        = state.result_valid;
  assign result              = state.result;
  assign branch_taken        = state.branch_taken;
  assign branch_target       = state.branch_target;
  assign illegal_instruction = state.illegal_instruction;

endmodule : custom_mac_simd_datapath

`default_nettype wire

// file: sim/operand_regfile.sv
// Register file model that answers the datapath's operand reads.
`timescale 1ns/1ns
`default_nettype none
module operand_regfile (
  input  wire logic [31:0] instruction,
  output logic      [31:0] source_one,
  output logic      [31:0] source_two,
  output logic      [31:0] destination_old
);
  // Loaded by the bench between issues; entries other than x0 stay unknown until loaded.
  logic [31:0] regs [32];
  initial regs[0] = 32'h0;
  // Reads follow the register fields of whatever word is presented.
  assign source_one      = regs[instruction[19:15]];
  assign source_two      = regs[instruction[24:20]];
  assign destination_old = regs[instruction[11:7]];
endmodule : operand_regfile
`default_nettype wire

// file: sim/custom_mac_simd_datapath_sva.sv
// Concurrent checks on issue, branch and decode behaviour of the datapath.
`timescale 1ns/1ns
`default_nettype none
module mac_simd_checker
  import mac_simd_pkg::*;
#(
  parameter bit custom_extension_enable_param = 1'b1
) (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        issue_valid,
  input wire logic        simd_valid,
  input wire logic [31:0] instruction,
  input wire logic [31:0] program_counter,
  input wire logic [31:0] source_one,
  input wire logic        result_valid,
  input wire logic [31:0] result,
  input wire logic        branch_taken,
  input wire logic [31:0] branch_target,
  input wire logic        illegal_instruction
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Target and compare rebuilt from the raw word, since the offset is split.
  logic [31:0] target;
  logic        same;
  logic        on;
  assign target = program_counter + {{19{instruction[31]}}, instruction[31],
                  instruction[7], instruction[30:25], instruction[11:8], 1'b0};
  assign same   = source_one == {{27{instruction[24]}}, instruction[24:20]};
  assign on     = custom_extension_enable_param;
  sequence branch_s;
    issue_valid && !simd_valid && instruction[6:0] == opcode_branch_imm
      && instruction[14:13] == 2'h3;
  endsequence
  sequence half_s;
    issue_valid && !simd_valid && instruction[6:0] == opcode_half_mul
      && instruction[14];
  endsequence
  issue_pulse_a:
    assert property ((issue_valid || simd_valid) |=>
      result_valid ^ illegal_instruction)
    else $error("no result pulse after an issue");
  idle_quiet_a:
    assert property (!issue_valid && !simd_valid |=> !result_valid
      && !branch_taken && !illegal_instruction)
    else $error("output pulse without an issue");
  equal_branch_a:
    assert property (branch_s ##0 !instruction[12]
      |=> branch_taken == $past(same))
    else $error("equal branch decision wrong");
  unequal_branch_a:
    assert property (branch_s ##0 instruction[12]
      |=> branch_taken != $past(same))
    else $error("unequal branch decision wrong");
  branch_target_a:
    assert property (branch_s |=> branch_target == $past(target))
    else $error("branch target wrong");
  branch_legal_a:
    assert property (branch_s |=> !illegal_instruction && result == 32'h0)
    else $error("branch decoded as illegal");
  half_legal_a:
    assert property (half_s |=> illegal_instruction == !on)
    else $error("half multiply legality wrong");
  simd_lanes_a:
    assert property (simd_valid |=> !branch_taken && illegal_instruction == !on)
    else $error("packed operation legality wrong");
endmodule : mac_simd_checker
bind custom_mac_simd_datapath mac_simd_checker #(
  .custom_extension_enable_param(custom_extension_enable_param)
) mac_simd_checker_inst (
  .clock(clock), .nrst(nrst), .issue_valid(issue_valid),
  .simd_valid(simd_valid), .instruction(instruction),
  .program_counter(program_counter), .source_one(source_one),
  .result_valid(result_valid), .result(result),
  .branch_taken(branch_taken), .branch_target(branch_target),
  .illegal_instruction(illegal_instruction)
);
`default_nettype wire

// file: sim/custom_mac_simd_datapath_tb.sv
// Self-checking bench for the multiply and packed-lane datapath.
`timescale 1ns/1ns
`default_nettype none
module custom_mac_simd_datapath_tb;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        issue_valid = 1'b0;
  logic        simd_valid = 1'b0;
  logic        simd_byte_lanes = 1'b0;
  logic [2:0]  simd_operation = 3'h0;
  logic [1:0]  simd_operand_mode = 2'h0;
  logic        simd_unsigned = 1'b0;
  logic [5:0]  simd_immediate = 6'h0;
  logic [31:0] instruction = 32'h0;
  logic [31:0] program_counter = 32'h0;
  logic [31:0] source_one, source_two, destination_old, result, branch_target;
  logic        result_valid, branch_taken, illegal_instruction, off_illegal;
  int          failures = 0;
  int          n_checks = 0;
  custom_mac_simd_datapath custom_mac_simd_datapath_inst (.*);
  // A copy with the extension off sees the same traffic.
  custom_mac_simd_datapath #(.custom_extension_enable_param(1'b0))
    disabled_custom_mac_simd_datapath_inst (.*, .result_valid(), .result(),
    .branch_taken(), .branch_target(), .illegal_instruction(off_illegal));
  operand_regfile operand_regfile_inst (.*);
  // Free-running core clock.
  initial forever #5 clock = ~clock;
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Loads x1..x3, issues for one cycle, returns while the answer stands.
  // A packed op raises the scalar valid too, so its priority is exercised.
  task automatic op(input logic [31:0] ins, a, b, d, input logic vec);
    @(negedge clock);
    operand_regfile_inst.regs[1] = a;
    operand_regfile_inst.regs[2] = b;
    operand_regfile_inst.regs[3] = d;
    instruction = ins | 32'h0000_8000;
    issue_valid = 1'b1;
    simd_valid  = vec;
    @(negedge clock);
    issue_valid = 1'b0;
    simd_valid  = 1'b0;
  endtask : op
  task automatic t_branch();
    logic [12:0] off [4] = '{13'h1000, 13'h0ffe, 13'h0002, 13'h1ffe};
    logic [4:0]  imm [4] = '{5'h1d, 5'h05, 5'h10, 5'h0f};
    logic [31:0] src [4] = '{32'hffff_fffd, 32'h4, 32'hf, 32'hf};
    program_counter = 32'h0000_8000;
    for (int i = 0; i < 4; i++) begin
      op({off[i][12], off[i][10:5], imm[i], 5'h0, 2'h3, 1'(i / 2),
          off[i][4:1], off[i][11], 7'h0b}, src[i], 0, 0, 1'b0);
      chk("taken", i % 2 == 0, branch_taken);
      chk("target", 32'h8000 + {{19{off[i][12]}}, off[i]}, branch_target);
      chk("valid", 1, result_valid);
      chk("off_illegal", 0, off_illegal);
    end
    $display("branch test done");
  endtask : t_branch
  task automatic t_full();
    logic [31:0] a = 32'h1234_5678, b = 32'h9abc_def1, d = 32'h1111_1111;
    op({7'h48, 5'h2, 5'h0, 3'h3, 5'h3, 7'h2b}, a, b, d, 1'b0);
    chk("mac", d + a * b, result);
    chk("off_illegal", 1, off_illegal);
    op({7'h49, 5'h2, 5'h0, 3'h3, 5'h3, 7'h2b}, a, b, d, 1'b0);
    chk("msu", d - a * b, result);
    op(32'h0000_007f, a, b, d, 1'b0);
    chk("unknown", 1, illegal_instruction);
    $display("full multiply test done");
  endtask : t_full
  function automatic logic signed [33:0] ext(input logic [31:0] w,
                                             input int n, input logic sg);
    return (sg && w[n-1]) ? 34'(w) - (34'h1 << n) : 34'(w);
  endfunction : ext
  // Every group and variant, with a zero and a non-zero post shift.
  task automatic t_half();
    logic [31:0] a = 32'h8003_fffd, b = 32'hfff9_0005, d = 32'h0001_2345;
    logic signed [33:0] x, y, s;
    logic [4:0] sh;
    for (int f = 4; f < 8; f++) begin
      for (int v = 0; v < 4; v++) begin
        for (int k = 0; k < 2; k++) begin
          sh = k ? 5'h5 : 5'h0;
          x = ext(v[0] ? a[31:16] : a[15:0], 16, !f[0]);
          y = ext(v[0] ? b[31:16] : b[15:0], 16, !f[0]);
          s = x * y + (f[1] ? ext(d, 32, !f[0]) : 34'sh0)
            + ((v[1] && sh != 5'h0) ? 34'sh1 <<< (sh - 5'h1) : 34'sh0);
          op({2'(v), sh, 5'h2, 5'h0, 3'(f), 5'h3, 7'h5b}, a, b, d, 1'b0);
          chk("half", 32'(s >>> sh), result);
          chk("off_illegal", 1, off_illegal);
        end
      end
    end
    $display("half multiply test done");
  endtask : t_half
  // Controls packed as lanes, operation, mode, unsigned, immediate.
  task automatic t_simd();
    logic [12:0] c [10] = '{13'h1000, 13'h0280, 13'h11aa, 13'h1dea,
                            13'h0a00, 13'h1500, 13'h0680, 13'h19bf,
                            13'h1200, 13'h01aa};
    logic [31:0] a [10] = '{32'h80ff7f01, 32'h00010000, 32'h01020304,
                            32'h10ff2a30, 32'h80000005, 32'hf0f0ff00,
                            32'h12000034, 32'h0f00a55a, 32'h00ff0102,
                            32'h00010020};
    logic [31:0] b [10] = '{32'h80017f01, 32'hdead0002, 0, 0,
                            32'h7fff0003, 32'h3c3c0ff0, 32'hffff0f0f, 0,
                            32'h01010203, 0};
    logic [31:0] e [10] = '{32'h0000fe02, 32'hfffffffe, 32'hebecedee,
                            32'h2aff2a30, 32'h80000003, 32'h30300f00,
                            32'h1f0f0f3f, 32'hf0ff5aa5, 32'hfffeffff,
                            32'hffeb000a};
    for (int i = 0; i < 10; i++) begin
      {simd_byte_lanes, simd_operation, simd_operand_mode, simd_unsigned,
       simd_immediate} = c[i];
      op(32'h0020_0180, a[i], b[i], 0, 1'b1);
      chk("simd", e[i], result);
      chk("off_illegal", 1, off_illegal);
    end
    $display("packed lane test done");
  endtask : t_simd
  // Reset in mid-run clears a standing answer at once; issue works after.
  task automatic t_reset();
    op(32'h0020_0180, 32'h0001_0020, 0, 0, 1'b1);
    chk("pre reset", 32'hffeb_000a, result);
    nrst = 1'b0;
    #1;
    chk("reset result", 0, result);
    chk("reset valid", 0, result_valid);
    @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    chk("after reset", 0, result_valid);
    op(32'h0020_0180, 32'h0001_0020, 0, 0, 1'b1);
    chk("post reset", 32'hffeb_000a, result);
    $display("reset test done");
  endtask : t_reset
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // Main sequence after ten cycles of reset.
  initial begin
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    chk("idle", 0, result_valid);
    t_branch();
    t_full();
    t_half();
    t_simd();
    t_reset();
    wrap_up();
  end
  // About 115 cycles are needed; over seventeen times that means a hang.
  initial begin
    #20000;
    failures++;
    wrap_up();
  end
endmodule : custom_mac_simd_datapath_tb
`default_nettype wire
